// ### src/drdt_pkg.sv
// shared constants for the dual reload down timer
package drdt_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  // count clock divider, stands in for the prescaled oscillator
  localparam int unsigned COUNT_DIV = 16;
  // high byte latch release time, microseconds, shortest figure
  localparam int unsigned LATCH_REL_US = 730;
  localparam int unsigned LATCH_REL_CYC = LATCH_REL_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_PRIO = 16'hff21;
  localparam logic [15:0] IDX_IEN = 16'hff23;
  localparam logic [15:0] IDX_IFLG = 16'hff25;
  localparam logic [15:0] IDX_MODE = 16'hff30;
  localparam logic [15:0] IDX_CH0 = 16'hff31;
  localparam logic [15:0] IDX_CH1 = 16'hff32;
  localparam logic [15:0] IDX_RLD0 = 16'hff33;
  localparam logic [15:0] IDX_RLD1 = 16'hff34;
  localparam logic [15:0] IDX_RB0 = 16'hff35;
  localparam logic [15:0] IDX_RB1 = 16'hff36;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned B_WIDE = 4;
  localparam int unsigned B_OUTPUT_CHANNEL_SELECT = 3;
  localparam int unsigned B_GATE = 2;
  localparam int unsigned B_CONT = 2;
  localparam int unsigned B_PSET = 1;
  localparam int unsigned B_RUN = 0;
  localparam int unsigned B_PRIO_LO = 2;
  localparam int unsigned B_PRIO_HI = 3;
  localparam int unsigned B_CH0 = 6;
  localparam int unsigned B_CH1 = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RELOAD_RST = 8'hff;
  localparam logic [7:0] READBACK_RST = 8'hff;

  typedef enum logic [0:0] {
    BUS_WAIT = 1'b0,
    BUS_DONE = 1'b1
  } drdt_bus_t;
endpackage : drdt_pkg

// ### src/drdt_tick.sv
// restartable divider giving a one-cycle enable pulse every div cycles
`timescale 1ns/1ns
`default_nettype none
module drdt_tick #(
  parameter int unsigned DIV = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart,
  output logic tick
);
  typedef struct packed {
    logic [16:0] cnt;
    logic tick;
  } drdt_tick_st_t;

  drdt_tick_st_t q, d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (restart)
    begin
      d.cnt = 17'h0;
    end
    else if (q.cnt == 17'(DIV - 1))
    begin
      d.cnt = 17'h0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 17'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

  a_tick_single: assert property (@(posedge mclk) disable iff (!rst_n)
    q.tick |=> !q.tick)
    else $error("divider tick longer than one cycle");
endmodule : drdt_tick
`default_nettype wire

// ### src/drdt_timer.sv
// two 8-bit reload down counters, joinable to 16 bits, on avalon-mm
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module drdt_timer #(
  parameter int unsigned RELEASE_CYC = drdt_pkg::LATCH_REL_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_level_flag_lo,
  input wire logic cpu_level_flag_hi,
  output logic timer_output_port_pin,
  output logic irq_request
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    drdt_pkg::drdt_bus_t st;
    logic waitreq;
    logic [7:0] rdata;
    logic wide;
    logic output_channel_select;
    logic gate;
    logic [1:0] cont;
    logic [1:0] run_req;
    logic [1:0] run;
    logic [1:0][7:0] rld;
    logic [1:0][7:0] cnt;
    logic [7:0] rb0;
    logic [7:0] rb1;
    logic hi_latched;
    logic [1:0] prio;
    logic [1:0] ien;
    logic [1:0] iflg;
    logic timer_output_signal;
    logic pin;
    logic irq;
  } drdt_state_t;

  drdt_state_t q, d;
  logic count_tick;
  logic release_tick;
  logic latch_now;
  logic prio_above;
  logic wr_acc;

  function automatic logic drdt_hit(input logic [17:0] a,
                                    input logic [15:0] idx);
    return a[17:2] == idx;
  endfunction : drdt_hit

  // ---------------------------------------------------------------
  // enable pulses
  // ---------------------------------------------------------------
  drdt_tick #(.DIV(drdt_pkg::COUNT_DIV)) u_count_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(1'b0),
    .tick(count_tick)
  );

  // restarted by each latch so the release lands a fixed time later
  drdt_tick #(.DIV(RELEASE_CYC)) u_release_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(latch_now),
    .tick(release_tick)
  );

  assign prio_above = q.prio > {cpu_level_flag_hi, cpu_level_flag_lo};
  assign wr_acc = (q.st == drdt_pkg::BUS_DONE) && avs_write &&
                  avs_byteenable[0];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [7:0] wd;
    logic [7:0] rd_val;
    logic [1:0] pset;
    logic [1:0] uf;
    logic [1:0] en;
    logic bor;
    logic go;
    logic cap;
    logic sel;
    d = q;
    wd = avs_writedata[7:0];
    rd_val = 8'h00;
    pset = 2'b00;
    uf = 2'b00;
    bor = 1'b0;
    go = 1'b0;
    en = 2'b00;
    sel = 1'b0;
    latch_now = 1'b0;
    cap = (q.st == drdt_pkg::BUS_WAIT) && avs_read;

    // register read mux, unmapped reads return zero
    if (drdt_hit(avs_address, drdt_pkg::IDX_MODE))
      rd_val = 8'h00 | (8'(q.wide) << drdt_pkg::B_WIDE) |
               (8'(q.output_channel_select) << drdt_pkg::B_OUTPUT_CHANNEL_SELECT) |
               (8'(q.gate) << drdt_pkg::B_GATE);
    else if (drdt_hit(avs_address, drdt_pkg::IDX_CH0))
      rd_val = (8'(q.cont[0]) << drdt_pkg::B_CONT) |
               (8'(q.run[0] | q.run_req[0]) << drdt_pkg::B_RUN);
    else if (drdt_hit(avs_address, drdt_pkg::IDX_CH1))
      rd_val = (8'(q.cont[1]) << drdt_pkg::B_CONT) |
               (8'(q.run[1] | q.run_req[1]) << drdt_pkg::B_RUN);
    else if (drdt_hit(avs_address, drdt_pkg::IDX_RLD0))
      rd_val = q.rld[0];
    else if (drdt_hit(avs_address, drdt_pkg::IDX_RLD1))
      rd_val = q.rld[1];
    else if (drdt_hit(avs_address, drdt_pkg::IDX_RB0))
      rd_val = q.rb0;
    else if (drdt_hit(avs_address, drdt_pkg::IDX_RB1))
      rd_val = q.rb1;
    else if (drdt_hit(avs_address, drdt_pkg::IDX_PRIO))
      rd_val = 8'(q.prio) << drdt_pkg::B_PRIO_LO;
    else if (drdt_hit(avs_address, drdt_pkg::IDX_IEN))
      rd_val = 8'(q.ien) << drdt_pkg::B_CH0;
    else if (drdt_hit(avs_address, drdt_pkg::IDX_IFLG))
      rd_val = 8'(q.iflg) << drdt_pkg::B_CH0;

    // one wait cycle, then the access completes
    case (q.st)
      drdt_pkg::BUS_WAIT:
      begin
        if (avs_read || avs_write)
        begin
          d.st = drdt_pkg::BUS_DONE;
          d.waitreq = 1'b0;
          d.rdata = avs_read ? rd_val : 8'h00;
        end
      end
      drdt_pkg::BUS_DONE:
      begin
        d.st = drdt_pkg::BUS_WAIT;
        d.waitreq = 1'b1;
      end
      default:
      begin
        d.st = drdt_pkg::BUS_WAIT;
        d.waitreq = 1'b1;
      end
    endcase

    // counting; ch1 is clocked by ch0 borrow in wide mode
    if (count_tick)
    begin
      for (int i = 0; i < 2; i++)
      begin
        go = (i == 0) ? q.run[0] : (q.wide ? bor : q.run[1]);
        bor = 1'b0;
        if (go)
        begin
          if (q.cnt[i] == 8'h00)
          begin
            d.cnt[i] = q.rld[i];
            bor = 1'b1;
          end
          else
          begin
            d.cnt[i] = q.cnt[i] - 8'h01;
          end
        end
        uf[i] = bor;
      end
      // a stop takes effect here, after this last decrement
      d.run = q.run_req;
      // in wide mode ch1 underflow is the combined underflow
      if (q.wide && uf[1] && !q.cont[0])
      begin
        d.run[0] = 1'b0;
        d.run_req[0] = 1'b0;
      end
      for (int i = 0; i < 2; i++)
      begin
        if (!q.wide && uf[i] && !q.cont[i])
        begin
          d.run[i] = 1'b0;
          d.run_req[i] = 1'b0;
        end
      end
    end

    // register writes, readback registers ignore writes
    if (wr_acc)
    begin
      if (drdt_hit(avs_address, drdt_pkg::IDX_MODE))
      begin
        d.wide = wd[drdt_pkg::B_WIDE];
        d.output_channel_select = wd[drdt_pkg::B_OUTPUT_CHANNEL_SELECT];
        d.gate = wd[drdt_pkg::B_GATE];
      end
      if (drdt_hit(avs_address, drdt_pkg::IDX_CH0))
      begin
        d.cont[0] = wd[drdt_pkg::B_CONT];
        d.run_req[0] = wd[drdt_pkg::B_RUN];
        pset[0] = wd[drdt_pkg::B_PSET];
      end
      if (drdt_hit(avs_address, drdt_pkg::IDX_CH1))
      begin
        d.cont[1] = wd[drdt_pkg::B_CONT];
        d.run_req[1] = wd[drdt_pkg::B_RUN];
        pset[1] = wd[drdt_pkg::B_PSET] & ~q.wide;
      end
      if (drdt_hit(avs_address, drdt_pkg::IDX_RLD0))
        d.rld[0] = wd;
      if (drdt_hit(avs_address, drdt_pkg::IDX_RLD1))
        d.rld[1] = wd;
      if (drdt_hit(avs_address, drdt_pkg::IDX_PRIO))
        d.prio = wd[drdt_pkg::B_PRIO_HI:drdt_pkg::B_PRIO_LO];
      if (drdt_hit(avs_address, drdt_pkg::IDX_IEN))
        d.ien = wd[drdt_pkg::B_CH1:drdt_pkg::B_CH0];
    end

    // preset overrides the tick; wide preset loads both halves
    if (pset[0])
    begin
      d.cnt[0] = q.rld[0];
      if (q.wide)
        d.cnt[1] = q.rld[1];
    end
    if (pset[1])
      d.cnt[1] = q.rld[1];

    if (d.wide)
    begin
      d.run[1] = 1'b0;
      d.run_req[1] = 1'b0;
    end

    // flags: set beats a same-cycle clear
    d.iflg = q.iflg;
    if (wr_acc && drdt_hit(avs_address, drdt_pkg::IDX_IFLG))
      d.iflg = q.iflg & ~wd[drdt_pkg::B_CH1:drdt_pkg::B_CH0];
    d.iflg = d.iflg | {uf[1], uf[0] & ~q.wide};

    // timer output toggles on the selected underflow
    sel = q.wide ? 1'b1 : q.output_channel_select;
    if (uf[sel])
      d.timer_output_signal = ~q.timer_output_signal;
    // registered gate: the half-cycle hazard cannot reach the pin
    d.pin = q.gate ? q.timer_output_signal : 1'b1;

    en = {q.ien[1], q.ien[0] & ~q.wide};
    d.irq = (|(q.iflg & en)) && prio_above;

    // readback buffers, high byte frozen while latched
    d.rb0 = q.cnt[0];
    latch_now = cap && q.wide && drdt_hit(avs_address, drdt_pkg::IDX_RB0);
    if (latch_now)
      d.hi_latched = 1'b1;
    else if (q.hi_latched && (release_tick || !q.wide ||
             (cap && drdt_hit(avs_address, drdt_pkg::IDX_RB1))))
      d.hi_latched = 1'b0;
    if (!q.hi_latched && !latch_now)
      d.rb1 = q.cnt[1];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= drdt_pkg::BUS_WAIT;
      q.waitreq <= 1'b1;
      q.rld <= {drdt_pkg::RELOAD_RST, drdt_pkg::RELOAD_RST};
      q.cnt <= {drdt_pkg::RELOAD_RST, drdt_pkg::RELOAD_RST};
      q.rb0 <= drdt_pkg::READBACK_RST;
      q.rb1 <= drdt_pkg::READBACK_RST;
      q.pin <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_readdata = {24'h000000, q.rdata};
  assign avs_waitrequest = q.waitreq;
  assign timer_output_port_pin = q.pin;
  assign irq_request = q.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_wide_run_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    q.wide |-> !q.run[1] && !q.run_req[1])
    else $error("high channel runs in wide mode");

  a_oneshot_halt: assert property (@(posedge mclk) disable iff (!rst_n)
    count_tick && q.run[0] && q.cnt[0] == 8'h00 && !q.cont[0] &&
    !q.wide && !wr_acc |=> !q.run[0] && q.cnt[0] == $past(q.rld[0]))
    else $error("one-shot underflow did not halt with reload");

  a_cont_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    count_tick && q.run[1] && q.run_req[1] && q.cnt[1] == 8'h00 &&
    q.cont[1] && !q.wide && !wr_acc
    |=> q.run[1] && q.cnt[1] == $past(q.rld[1]))
    else $error("continuous underflow did not reload and run on");

  a_flag_on_uf: assert property (@(posedge mclk) disable iff (!rst_n)
    count_tick && q.run[1] && q.cnt[1] == 8'h00 && !q.wide
    |=> q.iflg[1])
    else $error("underflow did not set flag");

  a_wide_flag_low: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(q.iflg[0]) |-> !$past(q.wide))
    else $error("low flag set in wide mode");

  a_preset_load: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_acc && drdt_hit(avs_address, drdt_pkg::IDX_CH0) &&
    avs_writedata[drdt_pkg::B_PSET] |=> q.cnt[0] == $past(q.rld[0]))
    else $error("preset did not load counter");

  a_hi_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    q.hi_latched && $past(q.hi_latched) |-> $stable(q.rb1))
    else $error("latched high readback changed");

  a_gate_high: assert property (@(posedge mclk) disable iff (!rst_n)
    !q.gate |=> timer_output_port_pin)
    else $error("pin not high with gate off");

  a_irq_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    irq_request |-> $past(prio_above) && $past(q.iflg) != 2'b00)
    else $error("interrupt without flag and priority");

  a_bus_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    q.st == drdt_pkg::BUS_WAIT && (avs_read || avs_write)
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not in one wait cycle");
endmodule : drdt_timer
`default_nettype wire

// ### dv/drdt_timer_bench.sv
// self-checking bench for the dual reload down timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module drdt_timer_bench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic lvl_lo = 1'b0;
  logic lvl_hi = 1'b0;
  logic pin;
  logic irq;
  int failures = 0;
  int comparisons = 0;
  integer seed = 32'hcfa5;
  logic [7:0] v;
  logic [7:0] d;
  logic t;

  always #5 mclk = ~mclk;

  // short latch release keeps the run brief
  drdt_timer #(.RELEASE_CYC(50)) i_dut (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_level_flag_lo(lvl_lo), .cpu_level_flag_hi(lvl_hi),
    .timer_output_port_pin(pin), .irq_request(irq)
  );

  // ---------------------------------------------------------------
  // bus helpers
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [15:0] idx,
    input logic [7:0] wd, input logic [3:0] be, output logic [7:0] rd);
    int n;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= be;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      $display("[ERR] bus answer exp 0 got timeout");
    end
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [7:0] x;
    bus(1'b1, idx, wd, 4'hf, x);
  endtask : wr

  task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, 4'hf, x);
    `CHK($sformatf("reg %h", idx), e, x)
  endtask : rchk

  // bounded wait for a field to reach a value
  task automatic poll(input logic [15:0] idx, input logic [7:0] m,
    input logic [7:0] want);
    logic [7:0] x;
    int n;
    n = 0;
    x = ~want;
    while (((x & m) !== want) && n < 300)
    begin
      bus(1'b0, idx, 8'h00, 4'hf, x);
      n++;
    end
    if (n >= 300)
    begin
      failures++;
      $display("[ERR] poll %h exp %h got %h", idx, want, x & m);
    end
  endtask : poll

  task automatic pin_watch(input int n, output logic moved);
    logic p;
    p = pin;
    moved = 1'b0;
    repeat (n)
    begin
      @(posedge mclk);
      if (pin !== p)
        moved = 1'b1;
    end
  endtask : pin_watch

  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #200_000;
    failures++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    `CHK("pin", 1'b1, pin)
    `CHK("irq", 1'b0, irq)
    rchk(drdt_pkg::IDX_MODE, 8'h00);
    rchk(drdt_pkg::IDX_CH0, 8'h00);
    rchk(drdt_pkg::IDX_CH1, 8'h00);
    rchk(drdt_pkg::IDX_PRIO, 8'h00);
    rchk(drdt_pkg::IDX_IEN, 8'h00);
    rchk(drdt_pkg::IDX_IFLG, 8'h00);
    rchk(16'hff40, 8'h00);
    for (int c = 0; c < 2; c++)
    begin
      v = 8'($random(seed));
      rchk(drdt_pkg::IDX_RLD0 + c, 8'hff);
      rchk(drdt_pkg::IDX_RB0 + c, 8'hff);
      wr(drdt_pkg::IDX_RLD0 + c, v);
      bus(1'b1, drdt_pkg::IDX_RLD0 + c, ~v, 4'he, d);
      rchk(drdt_pkg::IDX_RLD0 + c, v);
      wr(drdt_pkg::IDX_RB0 + c, ~v);
      rchk(drdt_pkg::IDX_RB0 + c, 8'hff);
      wr(drdt_pkg::IDX_CH0 + c, 8'h02);
      rchk(drdt_pkg::IDX_CH0 + c, 8'h00);
      repeat (64) @(posedge mclk);
      rchk(drdt_pkg::IDX_RB0 + c, v);
    end
    // one-shot underflow stops the channel and reloads it
    wr(drdt_pkg::IDX_RLD0, 8'h03);
    wr(drdt_pkg::IDX_CH0, 8'h03);
    rchk(drdt_pkg::IDX_CH0, 8'h01);
    poll(drdt_pkg::IDX_CH0, 8'h01, 8'h00);
    rchk(drdt_pkg::IDX_CH0, 8'h00);
    rchk(drdt_pkg::IDX_RB0, 8'h03);
    rchk(drdt_pkg::IDX_IFLG, 8'h40);
    wr(drdt_pkg::IDX_IFLG, 8'h00);
    rchk(drdt_pkg::IDX_IFLG, 8'h40);
    wr(drdt_pkg::IDX_IFLG, 8'h40);
    rchk(drdt_pkg::IDX_IFLG, 8'h00);
    // continuous channel one drives the pin
    wr(drdt_pkg::IDX_RLD1, 8'h00);
    wr(drdt_pkg::IDX_MODE, 8'h0c);
    // preset too, so the first underflow comes within two ticks
    wr(drdt_pkg::IDX_CH1, 8'h07);
    pin_watch(40, t);
    `CHK("pin toggles", 1'b1, t)
    rchk(drdt_pkg::IDX_CH1, 8'h05);
    rchk(drdt_pkg::IDX_IFLG, 8'h80);
    wr(drdt_pkg::IDX_MODE, 8'h04);
    repeat (3) @(posedge mclk);
    pin_watch(64, t);
    `CHK("pin stays", 1'b0, t)
    wr(drdt_pkg::IDX_MODE, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK("pin", 1'b1, pin)
    wr(drdt_pkg::IDX_CH1, 8'h04);
    poll(drdt_pkg::IDX_CH1, 8'h01, 8'h00);
    rchk(drdt_pkg::IDX_CH1, 8'h04);
    // priority against cpu level, flag one pending
    wr(drdt_pkg::IDX_IEN, 8'h80);
    for (int p = 0; p < 4; p++)
    begin
      wr(drdt_pkg::IDX_PRIO, p[1:0] << 2);
      for (int l = 0; l < 4; l++)
      begin
        @(posedge mclk);
        lvl_lo <= l[0];
        lvl_hi <= l[1];
        repeat (3) @(posedge mclk);
        `CHK("irq", (p > l), irq)
      end
    end
    wr(drdt_pkg::IDX_IEN, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK("irq", 1'b0, irq)
    wr(drdt_pkg::IDX_IFLG, 8'hc0);
    // wide mode
    wr(drdt_pkg::IDX_MODE, 8'h10);
    rchk(drdt_pkg::IDX_MODE, 8'h10);
    wr(drdt_pkg::IDX_CH1, 8'h01);
    rchk(drdt_pkg::IDX_CH1, 8'h00);
    wr(drdt_pkg::IDX_RLD0, 8'h01);
    wr(drdt_pkg::IDX_RLD1, 8'h09);
    wr(drdt_pkg::IDX_CH0, 8'h02);
    rchk(drdt_pkg::IDX_RB0, 8'h01);
    rchk(drdt_pkg::IDX_RB1, 8'h09);
    wr(drdt_pkg::IDX_RLD1, 8'h05);
    wr(drdt_pkg::IDX_CH1, 8'h02);
    rchk(drdt_pkg::IDX_RB1, 8'h09);
    wr(drdt_pkg::IDX_CH0, 8'h03);
    poll(drdt_pkg::IDX_RB0, 8'hff, 8'h00);
    // one borrow tick passes while the high byte is held
    repeat (20) @(posedge mclk);
    rchk(drdt_pkg::IDX_RB1, 8'h05);
    rchk(drdt_pkg::IDX_RB1, 8'h04);
    wr(drdt_pkg::IDX_CH0, 8'h00);
    repeat (40) @(posedge mclk);
    wr(drdt_pkg::IDX_IFLG, 8'hc0);
    wr(drdt_pkg::IDX_RLD0, 8'h02);
    wr(drdt_pkg::IDX_RLD1, 8'h00);
    wr(drdt_pkg::IDX_CH0, 8'h07);
    repeat (120) @(posedge mclk);
    rchk(drdt_pkg::IDX_IFLG, 8'h80);
    rchk(drdt_pkg::IDX_CH0, 8'h05);
    wr(drdt_pkg::IDX_PRIO, 8'h0c);
    @(posedge mclk);
    lvl_lo <= 1'b0;
    lvl_hi <= 1'b0;
    wr(drdt_pkg::IDX_IEN, 8'h40);
    repeat (3) @(posedge mclk);
    `CHK("irq", 1'b0, irq)
    wr(drdt_pkg::IDX_IEN, 8'hc0);
    repeat (3) @(posedge mclk);
    `CHK("irq", 1'b1, irq)
    tally_and_finish;
  end
endmodule : drdt_timer_bench
`default_nettype wire
